// ---- pgpc_pkg.sv ----
package pgpc_pkg;
    // ----------------------------------------
    // register map (index, byte address is 4x)
    // ----------------------------------------
    localparam logic [15:0] PIN6_IDX  = 16'h403d;
    localparam logic [15:0] PIN7_IDX  = 16'h403e;
    localparam logic [15:0] STAT_IDX  = 16'h4040;
    localparam logic [15:0] CTL_RST   = 16'ha400;
    localparam logic [15:0] CTL_WMASK = 16'hfe8f;
    // ----------------------------------------
    // control field positions
    // ----------------------------------------
    localparam int DIR_B  = 15;
    localparam int PULL_H = 14;
    localparam int PULL_L = 13;
    localparam int IRQM_B = 12;
    localparam int POL_B  = 10;
    localparam int OD_B   = 9;
    localparam int ENA_B  = 7;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h2;
    // ----------------------------------------
    // function codes
    // ----------------------------------------
    localparam logic [3:0] FN_IN_LONG   = 4'h0;
    localparam logic [3:0] FN_ONOFF     = 4'h2;
    localparam logic [3:0] FN_SLPWK     = 4'h3;
    localparam logic [3:0] FN_SLPWK_L   = 4'h4;
    localparam logic [3:0] FN_SLEEP     = 4'h5;
    localparam logic [3:0] FN_PWRON     = 4'h6;
    localparam logic [3:0] FN_WDOG      = 4'h7;
    localparam logic [3:0] FN_VSEL1     = 4'h8;
    localparam logic [3:0] FN_VSEL2     = 4'h9;
    localparam logic [3:0] FN_HWEN1     = 4'ha;
    localparam logic [3:0] FN_HWEN2     = 4'hb;
    localparam logic [3:0] FN_HWCT1     = 4'hc;
    localparam logic [3:0] FN_HWCT2     = 4'hd;
    localparam logic [3:0] FN_HWCT1_L   = 4'he;
    localparam logic [3:0] FN_HWCT2_L   = 4'hf;
    localparam logic [3:0] FN_OUT_SW    = 4'h0;
    // ----------------------------------------
    // debounce timing, 50 MHz clock
    // ----------------------------------------
    localparam int CLK_MHZ     = 50;
    localparam int DEB_NORM_US = 100;
    localparam int DEB_LONG_US = 1000;
    localparam int DEB_NORM_CYC = DEB_NORM_US * CLK_MHZ;
    localparam int DEB_LONG_CYC = DEB_LONG_US * CLK_MHZ;
endpackage : pgpc_pkg

// ---- pgpc_top.sv ----
// How it works
// R1: enable clear tri-states pin; set: output if direction 0, input if 1
// R2: pull field 14:13 picks none, pull-down, pull-up; 11 reserved
// R3: edge mode 0 interrupts on active edge given by polarity
// R4: edge mode 1 interrupts on both edges regardless of polarity
// R5: polarity 1 keeps pin active high, 0 inverts it
// R6: open-drain bit selects CMOS or open-drain output driver
// R7: input codes 0 and 1 are plain inputs, long or normal debounce
// R8: input codes 2 to 6 are power and sleep requests
// R9: input code 7 watchdog reset, 8 and 9 voltage-scale selects
// R10: input codes 10 to 15 hardware enables and controls
// R11: output code 0 drives software level, 1 the 32 kHz clock
// R12: output codes 2 to 4 drive state indications; 5 to 7 drive low
// R13: output codes 8 to 11 drive scaling done and power enables
// R14: output codes 12 to 15 supply good, power good, 2 MHz, aux reset
// R15: function decoded by input or output table per direction
// R16: debounce intervals are module parameters
`timescale 1ns/10ps
module pgpc_top
    import pgpc_pkg::*;
#(
    parameter int NORM_CYC = DEB_NORM_CYC,
    parameter int LONG_CYC = DEB_LONG_CYC
)(
    input  wire logic        pclk,         // 50 MHz clock
    input  wire logic        presetn,      // async reset
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb write
    input  wire logic [17:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    input  wire logic [1:0]  pad_in,       // pin levels, 0 is pin six
    output logic      [1:0]  pad_out,      // pin drive level
    output logic      [1:0]  pad_oe_n,     // low while driving
    output logic      [1:0]  pull_up_en,   // pull-up on
    output logic      [1:0]  pull_dn_en,   // pull-down on
    output logic      [1:0]  pin_irq,      // edge event pulse
    input  wire logic [11:0] out_src,      // output role sources
    output logic             onoff_req,    // power on/off request
    output logic             sleepwake_req, // sleep/wake request
    output logic             sleep_req,    // sleep request
    output logic             poweron_req,  // power-on request
    output logic             wdog_reset,   // watchdog reset input
    output logic             voltage_scale_select_one, // scaling select 1
    output logic             voltage_scale_select_two, // scaling select 2
    output logic      [1:0]  hw_enable,    // hardware enables
    output logic      [1:0]  hw_control    // hardware controls
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0][15:0] ctl;
        logic [1:0][19:0] cnt;
        logic [1:0]       sy1;
        logic [1:0]       sy2;
        logic [1:0]       deb;
        logic [11:0]      ss1;
        logic [11:0]      ss2;
        logic [31:0]      rdata;
        logic             rdy;
        logic             err;
        logic [1:0]       dout;
        logic [1:0]       oe_n;
        logic [1:0]       pup;
        logic [1:0]       pdn;
        logic [1:0]       irq;
        logic [10:0]      role;
    } pgpc_state_t;

    pgpc_state_t st;
    pgpc_state_t next_st;

    logic [15:0] idx;
    logic        acc;
    logic        wr;
    logic [19:0] lim;
    logic        lvl;
    logic        fresh;
    logic        drv;
    logic        srcv;
    logic        is_in;

    assign idx = paddr[17:2];
    assign acc = psel && penable && st.rdy;
    assign wr  = acc && pwrite && !st.err;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        lim     = 20'h00000;
        lvl     = 1'b0;
        fresh   = 1'b0;
        drv     = 1'b0;
        srcv    = 1'b0;
        is_in   = 1'b0;
        // two-flop synchronisers
        next_st.sy1 = pad_in;
        next_st.sy2 = st.sy1;
        next_st.ss1 = out_src;
        next_st.ss2 = st.ss1;
        // apb: no wait state, answer in first access cycle
        next_st.rdy = psel && !penable && !st.rdy;
        next_st.err = 1'b0;  // error flag stands in the access cycle only
        if (psel && !penable)
        begin
            next_st.err   = 1'b0;
            next_st.rdata = 32'h00000000;
            unique case (idx)
                PIN6_IDX: next_st.rdata = {16'h0000, st.ctl[0]};
                PIN7_IDX: next_st.rdata = {16'h0000, st.ctl[1]};
                STAT_IDX: next_st.rdata = {28'h0000000, st.irq, st.deb};
                default:  next_st.err   = 1'b1;
            endcase
            if (pwrite)
                next_st.rdata = 32'h00000000;
        end
        if (wr && idx == PIN6_IDX)
            next_st.ctl[0] = pwdata[15:0] & CTL_WMASK;
        if (wr && idx == PIN7_IDX)
            next_st.ctl[1] = pwdata[15:0] & CTL_WMASK;
        next_st.role = 11'h000;
        for (int p = 0; p < 2; p++)
        begin
            // R16: debounce length
            unique case (st.ctl[p][3:0])
                FN_IN_LONG, FN_SLPWK_L, FN_HWCT1_L, FN_HWCT2_L:
                    lim = 20'(LONG_CYC - 1);
                default:
                    lim = 20'(NORM_CYC - 1);
            endcase
            // R7: debounce filter
            fresh = 1'b0;
            if (st.sy2[p] == st.deb[p])
                next_st.cnt[p] = 20'h00000;
            else if (st.cnt[p] >= lim)
            begin
                next_st.cnt[p] = 20'h00000;
                next_st.deb[p] = st.sy2[p];
                fresh          = 1'b1;
            end
            else
                next_st.cnt[p] = st.cnt[p] + 20'h00001;
            // R5: polarity applied to the filtered level
            lvl   = next_st.deb[p] ^ ~st.ctl[p][POL_B];
            is_in = st.ctl[p][ENA_B] && st.ctl[p][DIR_B];
            // R3: active edge only
            // R4: any edge
            next_st.irq[p] = is_in && fresh && (st.ctl[p][IRQM_B] || lvl);
            // R15: input table used when direction is input
            if (is_in)
            begin
                // R8: request roles
                // R9: watchdog and scaling selects
                // R10: hardware enables and controls
                unique case (st.ctl[p][3:0])
                    FN_ONOFF:              next_st.role[0]  |= lvl;
                    FN_SLPWK, FN_SLPWK_L:  next_st.role[1]  |= lvl;
                    FN_SLEEP:              next_st.role[2]  |= lvl;
                    FN_PWRON:              next_st.role[3]  |= lvl;
                    FN_WDOG:               next_st.role[4]  |= lvl;
                    FN_VSEL1:              next_st.role[5]  |= lvl;
                    FN_VSEL2:              next_st.role[6]  |= lvl;
                    FN_HWEN1:              next_st.role[7]  |= lvl;
                    FN_HWEN2:              next_st.role[8]  |= lvl;
                    FN_HWCT1, FN_HWCT1_L:  next_st.role[9]  |= lvl;
                    FN_HWCT2, FN_HWCT2_L:  next_st.role[10] |= lvl;
                    default:               next_st.role    = next_st.role;
                endcase
            end
            // R11: software level or 32 kHz clock
            // R12: state indications, reserved codes low
            // R13: scaling done and power enables
            // R14: supply good, power good, 2 MHz, aux reset
            unique case (st.ctl[p][3:0])
                4'h0:               srcv = st.ctl[p][11];
                4'h1:               srcv = st.ss2[0];
                4'h2, 4'h3, 4'h4:   srcv = st.ss2[st.ctl[p][1:0] - 2'h1];
                4'h5, 4'h6, 4'h7:   srcv = 1'b0;
                default:            srcv = st.ss2[4'(st.ctl[p][3:0] - 4'h4)];
            endcase
            // R1: drive only when enabled and output
            drv = st.ctl[p][ENA_B] && !st.ctl[p][DIR_B];
            // R5: output polarity
            next_st.dout[p] = srcv ^ ~st.ctl[p][POL_B];
            // R6: open drain releases a high level
            next_st.oe_n[p] = !drv || (st.ctl[p][OD_B] && next_st.dout[p]);
            // R2: pull resistor select
            next_st.pup[p] = st.ctl[p][PULL_H:PULL_L] == PULL_UP;
            next_st.pdn[p] = st.ctl[p][PULL_H:PULL_L] == PULL_DOWN;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st      <= '0;
            st.ctl  <= {CTL_RST, CTL_RST};
            st.oe_n <= 2'h3;
            st.pdn  <= 2'h3;
        end
        else
            st <= next_st;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata        = st.rdata;
    assign pready        = st.rdy;
    assign pslverr       = st.err;
    assign pad_out       = st.dout;
    assign pad_oe_n      = st.oe_n;
    assign pull_up_en    = st.pup;
    assign pull_dn_en    = st.pdn;
    assign pin_irq       = st.irq;
    assign onoff_req     = st.role[0];
    assign sleepwake_req = st.role[1];
    assign sleep_req     = st.role[2];
    assign poweron_req   = st.role[3];
    assign wdog_reset    = st.role[4];
    assign voltage_scale_select_one = st.role[5];
    assign voltage_scale_select_two = st.role[6];
    assign hw_enable     = st.role[8:7];
    assign hw_control    = st.role[10:9];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // R1: tri-state while disabled
    tri_state_a: assert property (!st.ctl[1][ENA_B] |=> pad_oe_n[1])  // R1
        else $error("pin seven driven while disabled");
    // R1: input never drives
    input_hiz_a: assert property ($past(st.ctl[0][DIR_B]) |-> pad_oe_n[0])  // R1
        else $error("pin six driven as input");
    // R2: pull settings
    pull_sel_a: assert property (  // R2
        pull_up_en[1] == ($past(st.ctl[1][PULL_H:PULL_L]) == PULL_UP)
        && pull_dn_en[1] == ($past(st.ctl[1][PULL_H:PULL_L]) == PULL_DOWN))
        else $error("pull enables disagree with field");
    // R3: no interrupt on inactive edge
    edge_one_a: assert property (pin_irq[1] && !$past(st.ctl[1][IRQM_B])  // R3
        |-> st.deb[1] == $past(st.ctl[1][POL_B]))
        else $error("wrong edge interrupt");
    // R4: any edge in mode one
    edge_both_a: assert property ($changed(st.deb[1]) && $past(st.ctl[1][IRQM_B])
        && $past(st.ctl[1][ENA_B] && st.ctl[1][DIR_B]) |-> pin_irq[1])  // R4
        else $error("missed edge interrupt");
    // R6: open drain never drives high
    open_drain_a: assert property (st.ctl[1][OD_B] && $stable(st.ctl[1]) && !pad_oe_n[1]
        |-> pad_out[1] == 1'b0)  // R6
        else $error("open drain drove high");
    // R12: reserved code 5 drives low level at polarity 1
    rsvd_low_a: assert property (st.ctl[1][3:0] == 4'h5 && st.ctl[1][POL_B]
        && $stable(st.ctl[1]) |=> !pad_out[1])  // R12
        else $error("reserved code drove high");
    // R15: on/off request quiet in output mode
    role_dir_a: assert property (!st.ctl[0][DIR_B] && !st.ctl[1][DIR_B]
        && $stable(st.ctl) |=> onoff_req == 1'b0)  // R15
        else $error("input role active in output mode");
    // R8: request follows pin
    req_follow_a: assert property (st.ctl[1] == 16'ha482 && st.ctl[0][3:0] != 4'h2
        && $stable(st.ctl) |=> onoff_req == st.deb[1])  // R8
        else $error("request does not follow pin");
    // R16: debounce holds the filter until stable
    deb_hold_a: assert property ($changed(st.deb[0]) |-> $past(st.cnt[0]) != 20'h00000)  // R16
        else $error("debounce without count");
    // R1: enabled push-pull output drives
    drive_on_a: assert property (st.ctl[1][ENA_B] && !st.ctl[1][DIR_B]  // R1
        && !st.ctl[1][OD_B] && $stable(st.ctl[1]) |=> !pad_oe_n[1])
        else $error("enabled output not driven");
    // R14: supply good reaches the pin
    out_follow_a: assert property (st.ctl[1] == 16'h248c && $stable(st.ctl[1])  // R14
        |=> pad_out[1] == $past(st.ss2[8]))
        else $error("output role not followed");
    // R9: watchdog input follows pin
    wdog_follow_a: assert property (st.ctl[1] == 16'ha487 && !st.ctl[0][ENA_B]  // R9
        && $stable(st.ctl) |=> wdog_reset == st.deb[1])
        else $error("watchdog input does not follow pin");
    // R10: hardware control follows pin
    hwctl_follow_a: assert property (st.ctl[1] == 16'ha48e && !st.ctl[0][ENA_B]  // R10
        && $stable(st.ctl) |=> hw_control[0] == st.deb[1])
        else $error("hardware control does not follow pin");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");

    cov_irq_c:   cover property (pin_irq[1]);
    cov_out_c:   cover property (!pad_oe_n[1]);
    cov_err_c:   cover property (pready && pslverr);
    cov_req_c:   cover property (onoff_req);
    cov_both_c:  cover property (pin_irq[1] && st.ctl[1][IRQM_B]);
endmodule : pgpc_top

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    import pgpc_pkg::*;
    // ----------------------------------------
    // signals and design under test
    // ----------------------------------------
    logic        pclk, presetn, psel, penable, pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr;
    logic [1:0]  pad_in, pad_out, pad_oe_n, pull_up_en, pull_dn_en, pin_irq;
    logic [11:0] out_src;
    logic        onoff_req, sleepwake_req, sleep_req, poweron_req, wdog_reset;
    logic        voltage_scale_select_one, voltage_scale_select_two;
    logic [1:0]  hw_enable, hw_control;
    logic [10:0] roles;
    logic [39:0] apb_q[$], irq_q[$];
    int          n_fail, checks, seed;
    int          role_of[16] = '{-1, -1, 10, 9, 9, 8, 7, 6, 5, 4, 2, 3, 0, 1, 0, 1};
    int          src_of[16]  = '{-1, 0, 1, 2, 3, -1, -1, -1, 4, 5, 6, 7, 8, 9, 10, 11};

    assign roles = {onoff_req, sleepwake_req, sleep_req, poweron_req, wdog_reset,
                    voltage_scale_select_one, voltage_scale_select_two, hw_enable, hw_control};

    pgpc_top #(.NORM_CYC(4), .LONG_CYC(8)) pgpc_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en), .pin_irq(pin_irq), .out_src(out_src),
        .onoff_req(onoff_req), .sleepwake_req(sleepwake_req), .sleep_req(sleep_req),
        .poweron_req(poweron_req), .wdog_reset(wdog_reset),
        .voltage_scale_select_one(voltage_scale_select_one),
        .voltage_scale_select_two(voltage_scale_select_two),
        .hw_enable(hw_enable), .hw_control(hw_control));

    // ----------------------------------------
    // clock, compare and report tasks
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // apb transfer, expected answer noted first
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [39:0] exp);
        int n;
        n = 0;
        apb_q.push_back(exp);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            n_fail++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    // pin seven edge with expected event noted
    task automatic edge7(input logic lvl, input logic fire, input int role);
        if (fire)
            irq_q.push_back({27'h0, 2'b10, (role < 0) ? 11'h0 : 11'h1 << role});
        pad_in[1] <= lvl;
        idle(25);
    endtask : edge7

    // ----------------------------------------
    // monitors: each result takes oldest note
    // ----------------------------------------
    always @(posedge pclk)
    begin
        if (pready === 1'b1)
            chk({7'h0, pslverr, prdata}, (apb_q.size() > 0) ? apb_q.pop_front() : '1);
        if (pin_irq !== 2'b00)
            chk({27'h0, pin_irq, roles}, (irq_q.size() > 0) ? irq_q.pop_front() : '1);
    end

    // disabled pin six toggles at random
    always @(posedge pclk)
        pad_in[0] <= presetn ? 1'($random(seed)) : 1'b0;

    initial
    begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        final_report;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] v;
        seed = 32'hb93dc6d1;
        {psel, penable, pwrite, paddr, pwdata, pad_in[1], out_src} <= '0;
        presetn <= 1'b0;
        n_fail = 0;
        checks = 0;
        idle(10);
        presetn <= 1'b1;
        apb(1'b0, PIN6_IDX, 32'h0, {8'h0, 32'h0000a400});
        apb(1'b0, PIN7_IDX, 32'h0, {8'h0, 32'h0000a400});
        chk({pad_oe_n, pull_dn_en, pull_up_en}, 40'h3c);
        apb(1'b0, 16'h403f, 32'h0, {8'h1, 32'h0});
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            apb(1'b1, PIN7_IDX, v, 40'h0);
            apb(1'b0, PIN7_IDX, 32'h0, {24'h0, v[15:0] & CTL_WMASK});
            apb(1'b1, PIN6_IDX, v & 32'hff7f, 40'h0);
            apb(1'b0, PIN6_IDX, 32'h0, {24'h0, v[15:0] & CTL_WMASK & 16'hff7f});
        end
        $display("test registers done");
        for (int p = 0; p < 3; p++)
        begin
            apb(1'b1, PIN7_IDX, 32'h8480 | (p << 13), 40'h0);
            idle(3);
            chk({pad_oe_n[1], pull_up_en[1], pull_dn_en[1]}, {1'b1, p == 2, p == 1});
        end
        $display("test pulls done");
        apb(1'b1, PIN7_IDX, 32'h2c80, 40'h0);
        idle(5);
        chk({pad_oe_n[1], pad_out[1]}, 40'h1);
        apb(1'b1, PIN7_IDX, 32'h2880, 40'h0);
        idle(5);
        chk(pad_out[1], 40'h0);
        apb(1'b1, PIN7_IDX, 32'h2e80, 40'h0);
        idle(5);
        chk(pad_oe_n[1], 40'h1);
        apb(1'b1, PIN7_IDX, 32'h2c00, 40'h0);
        idle(5);
        chk(pad_oe_n[1], 40'h1);
        apb(1'b1, PIN7_IDX, 32'h2680, 40'h0);
        idle(5);
        chk({pad_oe_n[1], pad_out[1]}, 40'h0);
        apb(1'b1, PIN6_IDX, 32'h2c80, 40'h0);
        idle(5);
        chk({pad_oe_n[0], pad_out[0]}, 40'h1);
        apb(1'b1, PIN6_IDX, 32'h0, 40'h0);
        for (int c = 1; c < 16; c++)
        begin
            out_src <= 12'($random(seed));
            apb(1'b1, PIN7_IDX, 32'h2480 | c, 40'h0);
            idle(6);
            chk(pad_out[1], (src_of[c] < 0) ? 40'h0 : out_src[src_of[c]]);
        end
        $display("test outputs done");
        // input roles with no event on fall, then both edges, then fall only
        for (int c = 2; c < 16; c++)
        begin
            apb(1'b1, PIN7_IDX, 32'ha480 | c, 40'h0);
            edge7(1'b1, 1'b1, role_of[c]);
            edge7(1'b0, 1'b0, -1);
        end
        apb(1'b1, PIN7_IDX, 32'hb481, 40'h0);
        edge7(1'b1, 1'b1, -1);
        edge7(1'b0, 1'b1, -1);
        apb(1'b1, PIN7_IDX, 32'ha081, 40'h0);
        edge7(1'b1, 1'b0, -1);
        edge7(1'b0, 1'b1, -1);
        chk(irq_q.size() + apb_q.size(), 40'h0);
        $display("test inputs done");
        final_report;
    end
endmodule : tb_top
